/* core/srs_top.v */
// srs_top.v: shift register set (converters, long static registers,
// bidirectional register) with an AXI4-Lite status/control slave.
// assumes all strobe and data inputs are synchronous to clk and that
// every strobe stays at one level for at least one clk cycle.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "srs_defines.vh"

module srs_top (
   input  wire                   clk,
   input  wire                   rst_n,
   // AXI4-Lite slave
   input  wire [`SRS_ADDR_W-1:0] s_axi_awaddr,
   input  wire                   s_axi_awvalid,
   output reg                    s_axi_awready,
   input  wire [31:0]            s_axi_wdata,
   input  wire [3:0]             s_axi_wstrb,
   input  wire                   s_axi_wvalid,
   output reg                    s_axi_wready,
   output reg  [1:0]             s_axi_bresp,
   output reg                    s_axi_bvalid,
   input  wire                   s_axi_bready,
   input  wire [`SRS_ADDR_W-1:0] s_axi_araddr,
   input  wire                   s_axi_arvalid,
   output reg                    s_axi_arready,
   output reg  [31:0]            s_axi_rdata,
   output reg  [1:0]             s_axi_rresp,
   output reg                    s_axi_rvalid,
   input  wire                   s_axi_rready,
   // four-stage parallel-to-serial converter
   input  wire                   convClk,
   input  wire                   convClear,
   input  wire                   convPreset1,
   input  wire                   convPreset2,
   input  wire [3:0]             convSrc1,
   input  wire [3:0]             convSrc2,
   input  wire                   convSerialIn,
   output wire [3:0]             convQ,
   // eight-stage gated serial-to-parallel register
   input  wire                   gateClk,
   input  wire                   gateInA,
   input  wire                   gateInB,
   output reg  [7:0]             gateQ,
   // dual 128-stage registers
   input  wire [1:0]             longClk,
   input  wire [1:0]             longDataIn,
   input  wire [1:0]             recirculateDataIn,
   input  wire [1:0]             recirculateSelectN,
   output wire [1:0]             longOut,
   // quad 32-stage registers
   input  wire                   quadClk,
   input  wire [3:0]             quadDataIn,
   output wire [3:0]             quadOut,
   // dual 50-stage registers
   input  wire [1:0]             medClk,
   input  wire [1:0]             medDataIn,
   output wire [1:0]             medOut,
   // four-stage right-left register
   input  wire                   bidirMode,
   input  wire                   bidirClkRight,
   input  wire                   bidirClkLeft,
   input  wire                   bidirSerialIn,
   input  wire [3:0]             leftParallelIn,
   output wire [3:0]             bidirQ
);

   // ==================================================================
   // strobe sampling
   reg        convClk_q;
   reg        gateClk_q;
   reg [1:0]  longClk_q;
   reg        quadClk_q;
   reg [1:0]  medClk_q;
   reg        rClk_q;
   reg        lClk_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         convClk_q <= 1'b0;
         gateClk_q <= 1'b0;
         longClk_q <= 2'h0;
         quadClk_q <= 1'b0;
         medClk_q  <= 2'h0;
         rClk_q    <= 1'b0;
         lClk_q    <= 1'b0;
      end else begin
         convClk_q <= convClk;
         gateClk_q <= gateClk;
         longClk_q <= longClk;
         quadClk_q <= quadClk;
         medClk_q  <= medClk;
         rClk_q    <= bidirClkRight;
         lClk_q    <= bidirClkLeft;
      end
   end

   wire       convRise = convClk & ~convClk_q;
   wire       convFall = ~convClk & convClk_q;
   wire       gateRise = gateClk & ~gateClk_q;
   wire       quadRise = quadClk & ~quadClk_q;
   wire       rRise    = bidirClkRight & ~rClk_q;
   wire       rFall    = ~bidirClkRight & rClk_q;
   wire       lRise    = bidirClkLeft & ~lClk_q;
   wire       lFall    = ~bidirClkLeft & lClk_q;

   reg  [`SRS_CTRL_INV_W-1:0] invMask_q;

   // ==================================================================
   // four-stage converter, master and slave ranks
   reg  [3:0] convM_q;
   reg  [3:0] convS_q;
   reg  [3:0] convLoad;

   always @* begin
      convLoad = convS_q;
      if (convPreset1 && !convPreset2)
         convLoad = convSrc1;
      else if (convPreset2 && !convPreset1)
         convLoad = convSrc2;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         convM_q <= 4'h0;
         convS_q <= 4'h0;
      end else if (convPreset1 || convPreset2) begin
         convM_q <= convLoad;
         convS_q <= convLoad;
      end else if (convClear) begin
         convM_q <= 4'h0;
         convS_q <= 4'h0;
      end else begin
         if (convRise)
            convM_q <= {convS_q[2:0], convSerialIn} ^ invMask_q;
         if (convFall)
            convS_q <= convM_q;
      end
   end
   assign convQ = convS_q;

   // ==================================================================
   // eight-stage gated register
   // and-gate of both inputs
   wire gateBit = gateInA & gateInB;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gateQ <= 8'h00;
      end else if (gateRise) begin
         gateQ <= {gateQ[6:0], gateBit};
      end else if (!gateBit) begin
         gateQ[0] <= 1'b0;
      end
   end

   // ==================================================================
   // dual 128-stage registers with recirculation
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gLong
         reg [`SRS_LONG_LEN-1:0] sr_q;
         reg                     recLatch_q;
         wire                    rise = longClk[g] & ~longClk_q[g];
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               sr_q       <= {`SRS_LONG_LEN{1'b0}};
               recLatch_q <= 1'b0;
            end else begin
               // recirculation level followed while clock low, held while high
               if (!longClk[g])
                  recLatch_q <= recirculateDataIn[g];
               // own clock; select; primary at clock high
               if (rise)
                  sr_q <= {sr_q[`SRS_LONG_LEN-2:0],
                           recirculateSelectN[g] ? longDataIn[g]
                                                 : recLatch_q};
            end
         end
         assign longOut[g] = sr_q[`SRS_LONG_LEN-1];
      end

      for (g = 0; g < 4; g = g + 1) begin : gQuad
         reg [`SRS_QUAD_LEN-1:0] sr_q;
         reg                     in_q;
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               sr_q <= {`SRS_QUAD_LEN{1'b0}};
               in_q <= 1'b0;
            end else begin
               // read while low, shift on rise, else hold
               if (!quadClk)
                  in_q <= quadDataIn[g];
               if (quadRise)
                  sr_q <= {sr_q[`SRS_QUAD_LEN-2:0], in_q};
            end
         end
         assign quadOut[g] = sr_q[`SRS_QUAD_LEN-1];
      end

      // same scheme at 50 stages, one clock each
      for (g = 0; g < 2; g = g + 1) begin : gMed
         reg [`SRS_MED_LEN-1:0] sr_q;
         reg                    in_q;
         wire                   rise = medClk[g] & ~medClk_q[g];
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               sr_q <= {`SRS_MED_LEN{1'b0}};
               in_q <= 1'b0;
            end else begin
               if (!medClk[g])
                  in_q <= medDataIn[g];
               if (rise)
                  sr_q <= {sr_q[`SRS_MED_LEN-2:0], in_q};
            end
         end
         assign medOut[g] = sr_q[`SRS_MED_LEN-1];
      end
   endgenerate

   // ==================================================================
   // four-stage right-left register, master and slave ranks
   reg [3:0] bidM_q;
   reg [3:0] bidS_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bidM_q <= 4'h0;
         bidS_q <= 4'h0;
      end else if (!bidirMode) begin
         if (rRise)
            bidM_q <= {bidS_q[2:0], bidirSerialIn};
         if (rFall)
            bidS_q <= bidM_q;
      end else begin
         // parallel load; wiring makes it a left shift
         if (lRise)
            bidM_q <= leftParallelIn;
         if (lFall)
            bidS_q <= bidM_q;
      end
   end
   assign bidirQ = bidS_q;

   // ==================================================================
   // AXI4-Lite slave: one write and one read in flight
   reg                   awHeld_q;
   reg                   wHeld_q;
   reg [`SRS_ADDR_W-1:0] awAddr_q;
   reg [31:0]            wData_q;
   reg                   wStrb0_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SRS_RESP_OKAY;
         awHeld_q      <= 1'b0;
         wHeld_q       <= 1'b0;
         awAddr_q      <= {`SRS_ADDR_W{1'b0}};
         wData_q       <= 32'h00000000;
         wStrb0_q      <= 1'b0;
         invMask_q     <= `SRS_CTRL_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q      <= 1'b1;
            awAddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q      <= 1'b1;
            wData_q      <= s_axi_wdata;
            wStrb0_q     <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (awHeld_q && wHeld_q && !s_axi_bvalid) begin
            awHeld_q     <= 1'b0;
            wHeld_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awAddr_q == `SRS_OFF_CTRL) begin
               s_axi_bresp <= `SRS_RESP_OKAY;
               if (wStrb0_q)
                  invMask_q <= wData_q[`SRS_CTRL_INV_LSB +:
                                       `SRS_CTRL_INV_W];
            end else if (awAddr_q == `SRS_OFF_STAT ||
                         awAddr_q == `SRS_OFF_TAPS) begin
               // read-only: write dropped
               s_axi_bresp <= `SRS_RESP_OKAY;
            end else begin
               s_axi_bresp <= `SRS_RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `SRS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `SRS_RESP_OKAY;
         if (s_axi_araddr == `SRS_OFF_CTRL)
            s_axi_rdata <= {28'h0000000, invMask_q};
         else if (s_axi_araddr == `SRS_OFF_STAT)
            s_axi_rdata <= {16'h0000, bidS_q, convS_q, gateQ};
         else if (s_axi_araddr == `SRS_OFF_TAPS)
            s_axi_rdata <= {24'h000000, medOut, quadOut, longOut};
         else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SRS_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule // srs_top

/* dv/srs_far_end.sv */
// srs_far_end.sv: surrounding logic that closes the left-shift path
// assumes bidirQ bit0 is the first stage
`timescale 1ns/10ps
module srs_far_end (
   input  logic [3:0] bidirQ,
   input  logic       leftFill,
   output logic [3:0] leftParallelIn
);
   assign leftParallelIn = {leftFill, bidirQ[3:1]};
endmodule // srs_far_end

/* dv/srs_top_assertions.sv */
// srs_top_assertions.sv: port-level checks for the shift register set
// assumes strobes are plain levels sampled by clk, as srs_top sees them
`timescale 1ns/10ps
module srs_chk (
   input logic       clk,
   input logic       rst_n,
   input logic       convClk,
   input logic       convClear,
   input logic       convPreset1,
   input logic       convPreset2,
   input logic [3:0] convSrc1,
   input logic [3:0] convSrc2,
   input logic [3:0] convQ,
   input logic       gateClk,
   input logic       gateInA,
   input logic       gateInB,
   input logic [7:0] gateQ,
   input logic [1:0] longClk,
   input logic [1:0] longOut,
   input logic       quadClk,
   input logic [3:0] quadOut,
   input logic       bidirMode,
   input logic       bidirClkRight,
   input logic       bidirClkLeft,
   input logic [3:0] bidirQ
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire pre = convPreset1 | convPreset2;
   // ====================================================================
   // converter
   property p_clear; convClear && !pre |=> convQ == 4'h0; endproperty
   a_clear: assert property (p_clear)
      else $error("clear did not zero the converter");
   property p_load;
      convPreset1 != convPreset2 |=>
         convQ == ($past(convPreset1) ? $past(convSrc1) : $past(convSrc2));
   endproperty
   a_load: assert property (p_load)
      else $error("preset loaded the wrong source");
   property p_both; convPreset1 && convPreset2 |=> $stable(convQ); endproperty
   a_both: assert property (p_both)
      else $error("clear or clock beat both presets");
   // a falling strobe is the only clocked way the slave rank moves
   property p_cause;
      $changed(convQ) |-> $past(pre) || $past(convClear) ||
         ($past(convClk, 2) && !$past(convClk));
   endproperty
   a_cause: assert property (p_cause)
      else $error("converter output moved off the trailing edge");
   // ====================================================================
   // gated eight-stage, static and right-left registers
   property p_gate0; !(gateInA && gateInB) |=> !gateQ[0]; endproperty
   a_gate0: assert property (p_gate0)
      else $error("first gated stage not cleared");
   property p_gshift;
      $rose(gateClk) |=>
         gateQ == {$past(gateQ[6:0]), $past(gateInA) & $past(gateInB)};
   endproperty
   a_gshift: assert property (p_gshift)
      else $error("gated register did not shift");
   property p_quad;
      $changed(quadOut) |-> $past(quadClk) && !$past(quadClk, 2);
   endproperty
   a_quad: assert property (p_quad)
      else $error("quad register moved without a rising clock");
   property p_long;
      $changed(longOut[0]) |-> $past(longClk[0]) && !$past(longClk[0], 2);
   endproperty
   a_long: assert property (p_long)
      else $error("long register moved without its own clock");
   property p_bidir;
      $changed(bidirQ) |-> ($past(bidirMode) ?
         $past(bidirClkLeft, 2) && !$past(bidirClkLeft) :
         $past(bidirClkRight, 2) && !$past(bidirClkRight));
   endproperty
   a_bidir: assert property (p_bidir)
      else $error("bidir register moved on the wrong clock");
endmodule // srs_chk

bind srs_top srs_chk u_srs_chk (.*);

/* dv/testbench.sv */
// testbench.sv: self-checking bench for srs_top
// assumes srs_far_end closes the left-shift loop of the bidir register
`timescale 1ns/10ps
`include "srs_defines.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
   fail_count++; $display("ERROR %0t: got %h want %h", $time, a, b); \
   end end
module testbench;
   logic        clk = 0, rst_n = 0, convSerialIn = 0, leftFill = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        convClk = 0, convClear = 0, convPreset1 = 0, convPreset2 = 0;
   logic [3:0]  convSrc1 = 0, convSrc2 = 0, convQ, e;
   logic        gateClk = 0, gateInA = 0, gateInB = 0;
   logic [7:0]  gateQ, g = 8'ha5;
   logic [1:0]  longClk = 0, longDataIn = 0, recirculateDataIn = 0;
   logic [1:0]  recirculateSelectN = 0, longOut, medClk = 0, medDataIn = 0;
   logic [1:0]  medOut;
   logic        quadClk = 0, bidirMode = 0, bidirClkRight = 0;
   logic        bidirClkLeft = 0, bidirSerialIn = 0;
   logic [3:0]  quadDataIn = 0, quadOut, leftParallelIn, bidirQ;
   logic [14:0] rows [5];
   int          fail_count = 0, cmp_count = 0, k;
   srs_top u_srs_top (.*);
   srs_far_end u_srs_far_end (.bidirQ(bidirQ), .leftFill(leftFill),
      .leftParallelIn(leftParallelIn));
   always #5 clk = ~clk;
   task cyc(input int n); repeat (n) @(posedge clk); endtask
   task stop_test;
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task tmo(input int n);
      if (n > 60) begin
         fail_count++;
         $display("ERROR %0t: bus timeout", $time);
         stop_test;
      end
   endtask
   // ====================================================================
   // bus master: hold each valid until its ready is sampled
   task wr(input [3:0] a, input [31:0] d, input [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         cyc(1);
         tmo(++n);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
      `CHK(s_axi_bresp, r)
   endtask
   task rd(input [3:0] a, input [31:0] d, input [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         cyc(1);
         tmo(++n);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
      `CHK({s_axi_rresp, s_axi_rdata}, {r, d})
   endtask
   // one strobe high for a cycle; the read lands after the fall is seen
   task pulse(input int w);
      case (w)
         0: convClk <= 1;
         1: gateClk <= 1;
         2: bidirClkRight <= 1;
         default: bidirClkLeft <= 1;
      endcase
      cyc(1);
      {convClk, gateClk, bidirClkRight, bidirClkLeft} <= 4'h0;
      cyc(2);
   endtask
   initial begin
      rows = '{{3'b100, 4'ha, 4'h5, 4'ha}, {3'b010, 4'ha, 4'h5, 4'h5},
         {3'b110, 4'h3, 4'hc, 4'h5}, {3'b001, 4'h3, 4'hc, 4'h0},
         {3'b101, 4'h9, 4'hc, 4'h9}};
      cyc(6);
      rst_n <= 1;
      rd(`SRS_OFF_CTRL, 32'h0, `SRS_RESP_OKAY);
      for (k = 0; k < 5; k++) begin
         {convPreset1, convPreset2, convClear, convSrc1, convSrc2}
            <= rows[k][14:4];
         cyc(1);
         {convPreset1, convPreset2, convClear} <= 3'h0;
         cyc(2);
         `CHK(convQ, rows[k][3:0])
      end
      e = 4'h9;
      for (k = 0; k < 8; k++) begin
         if (k == 4) wr(`SRS_OFF_CTRL, 32'hf, `SRS_RESP_OKAY);
         convSerialIn <= k[0];
         e = {e[2:0], k[0]} ^ (k > 3 ? 4'hf : 4'h0);
         pulse(0);
         `CHK(convQ, e)
      end
      wr(4'hc, 32'h0, `SRS_RESP_SLVERR);
      rd(4'hc, 32'h0, `SRS_RESP_SLVERR);
      wr(`SRS_OFF_STAT, 32'hffff, `SRS_RESP_OKAY);
      rd(`SRS_OFF_STAT, {20'h0, e, 8'h0}, `SRS_RESP_OKAY);
      $display("done: converter and registers");
      gateInA <= 1;
      for (k = 7; k >= 0; k--) begin
         gateInB <= g[k];
         pulse(1);
      end
      `CHK(gateQ, 8'ha5)
      {gateInA, gateInB} <= 2'b01;
      cyc(2);
      `CHK(gateQ[0], 1'b0)
      pulse(1);
      `CHK(gateQ, 8'h48)
      $display("done: gated register");
      e = 4'h0;
      for (k = 0; k < 4; k++) begin
         bidirSerialIn <= ~k[0];
         e = {e[2:0], ~k[0]};
         pulse(2);
         `CHK(bidirQ, e)
      end
      pulse(3);
      `CHK(bidirQ, e)
      {bidirMode, leftFill} <= 2'b11;
      cyc(1);
      for (k = 0; k < 2; k++) begin
         e = {1'b1, e[3:1]};
         pulse(3);
         `CHK(bidirQ, e)
      end
      pulse(2);
      `CHK(bidirQ, e)
      $display("done: bidir register");
      recirculateSelectN <= 2'b01;
      for (k = 1; k <= 130; k++) begin
         quadDataIn <= {4{k[0]}} ^ 4'h5;
         medDataIn <= {2{k[0]}} ^ 2'h1;
         longDataIn <= {2{k[0]}} ^ 2'h1;
         recirculateDataIn <= {2{k[0]}} ^ 2'h2;
         cyc(1);
         {quadClk, medClk, longClk} <= 5'h1f;
         cyc(2);
         {quadClk, medClk, longClk} <= 5'h0;
         if (k == 32 || k == 33) `CHK(quadOut, {4{~k[0]}} ^ 4'h5)
         if (k == 50 || k == 51) `CHK(medOut, {2{~k[0]}} ^ 2'h1)
         if (k >= 128) `CHK(longOut, {2{k[0]}})
      end
      cyc(20);
      `CHK(quadOut, 4'ha)
      rd(`SRS_OFF_TAPS, 32'ha8, `SRS_RESP_OKAY);
      $display("done: static registers");
      rst_n <= 0;
      cyc(2);
      `CHK({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid,
         s_axi_rvalid, convQ, gateQ, bidirQ, medOut, quadOut, longOut},
         29'h1c000000)
      rst_n <= 1;
      rd(`SRS_OFF_CTRL, 32'h0, `SRS_RESP_OKAY);
      $display("done: second reset");
      stop_test;
   end
endmodule // testbench

/* inc/srs_defines.vh */
// srs_defines.vh: register map, field positions, reset values and sizes
// for the shift register set. Included by the design and the bench.
`ifndef SRS_DEFINES_VH
`define SRS_DEFINES_VH

// =====================================================================
// register map (byte addresses)
`define SRS_ADDR_W      4
`define SRS_OFF_CTRL    4'h0
`define SRS_OFF_STAT    4'h4
`define SRS_OFF_TAPS    4'h8

// =====================================================================
// fields and reset values
`define SRS_CTRL_INV_LSB 0
`define SRS_CTRL_INV_W   4
`define SRS_CTRL_RST     4'h0
`define SRS_RESP_OKAY    2'b00
`define SRS_RESP_SLVERR  2'b10

// =====================================================================
// stage counts
`define SRS_LONG_LEN    128
`define SRS_QUAD_LEN    32
`define SRS_MED_LEN     50

`endif
